// *** src/bstf_bus_snoop_tag_filter.sv ***
`timescale 1ns/100ps
// Overview of operation
// R1 - One tag entry per cache set, selected by the address index field.
// R2 - Hit when the stored tag equals the bus address tag bits, or while R12 forces it.
// R3 - Offset bits never take part in the hit comparison.
// R4 - Entries have no valid bit, so a tag match alone makes a hit.
// R5 - Tag runs from bit 35 to bit 20 (1 MB) or 22 (4 MB), index just below.
// R6 - Offset is bits 4:0, 5:0 or 6:0 for 8, 16 or 32 word blocks.
// R7 - Static straps pick the split; at most 15 index bits, 32768 entries.
// R8 - Surplus tag bits stay in the compare, being merely redundant.
// R9 - Build variants use 32-word blocks with 1 MB or 4 MB geometry.
// R10 - The tag store is not reset and holds undefined data after reset.
// R11 - A read with write forthcoming overwrites the entry with the read tag.
// R12 - After that command every snoop hits until the next agent command.
// R13 - Outside a forced hit, tracked state blocks non-exclusive coherent reads if shared/invalid.
// R14 - The tracked state store is not reset either.
// R15 - The agent keeps and snoops a retained link address itself.
// R16 - Each coherent bus command is looked up; the answer comes next cycle.
// R17 - A line fill read writes the new tag into the indexed entry.
module bstf_bus_snoop_tag_filter
  import bstf_pkg::*;
#(
  parameter int IDX_W = MAX_IDX_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cfg_4mb,
  input wire bstf_blk_t cfg_blk,
  input wire bstf_snoop_req_t snoop_req,
  input wire bstf_agent_cmd_t agent_cmd,
  output bstf_snoop_rsp_t snoop_rsp,
  output logic cfg_err
);

  localparam int ENTRIES = 2 ** IDX_W;

  // Elaboration check on the store size
  if (IDX_W < 1 || IDX_W > MAX_IDX_W || ENTRIES > MAX_ENTRIES) begin : g_chk
    $error("bstf: IDX_W out of range");
  end

  // Package limits must agree with each other
  if (MAX_ENTRIES != 2 ** MAX_IDX_W) begin : g_pkg_chk
    $error("bstf: entry limit does not match index limit");
  end

  // Lowest index bit for a block size
  function automatic int bstf_off_lo(input bstf_blk_t b);
    int lo;
    lo = OFF_HI_32W + 1;
    case (b)
      BSTF_BLK_8W: lo = OFF_HI_8W + 1;
      BSTF_BLK_16W: lo = OFF_HI_16W + 1;
      default: lo = OFF_HI_32W + 1;
    endcase
    return lo;
  endfunction

  // Number of index bits for a geometry
  function automatic int bstf_idx_bits(input logic m4, input bstf_blk_t b);
    int tlo;
    tlo = m4 ? TAG_LO_4MB : TAG_LO_1MB;
    return tlo - bstf_off_lo(b);
  endfunction

  // Index field of an address; offset bits drop out here
  function automatic logic [IDX_W-1:0] bstf_index(
    input logic [ADDR_W-1:0] a,
    input logic m4,
    input bstf_blk_t b
  );
    logic [ADDR_W-1:0] s;
    logic [ADDR_W-1:0] mask;
    int w;
    w = bstf_idx_bits(m4, b);
    if (w > IDX_W) begin
      w = IDX_W;
    end
    s = a >> bstf_off_lo(b); // R3 R6
    mask = (ADDR_W'(1) << w) - ADDR_W'(1);
    return IDX_W'(s & mask); // R5
  endfunction

  // Tag field; bits 21:20 kept even for 4 MB as redundant bits
  function automatic logic [TAG_W-1:0] bstf_tag(input logic [ADDR_W-1:0] a);
    return a[TAG_HI:TAG_LO_1MB]; // R5 R8
  endfunction

  // Tag and state stores, one entry per set, no reset, no valid bit
  logic [TAG_W-1:0] tag_mem [ENTRIES]; // R1 R4 R10
  bstf_state_t state_mem [ENTRIES]; // R13 R14

  // Fields decoded from both ports
  logic [IDX_W-1:0] snp_idx;
  logic [IDX_W-1:0] agt_idx;
  logic [TAG_W-1:0] snp_tag;
  logic [TAG_W-1:0] agt_tag;

  // Lookup and write strobes
  logic snp_take;
  logic agt_tag_wr;
  logic agt_st_wr;

  // Filter decision
  logic tag_match;
  logic bus_inval;
  bstf_state_t cur_state;
  logic nonexcl_read;
  logic blocked;
  logic hit_now;

  // Forced hit and answer registers
  logic force_hit_q;
  logic force_hit_d;
  logic rsp_valid_q;
  logic rsp_hit_q;
  logic rsp_fwd_q;
  bstf_state_t rsp_state_q;

  // Address decode of both ports
  assign snp_idx = bstf_index(snoop_req.addr, cfg_4mb, cfg_blk); // R1
  assign agt_idx = bstf_index(agent_cmd.addr, cfg_4mb, cfg_blk);
  assign snp_tag = bstf_tag(snoop_req.addr);
  assign agt_tag = bstf_tag(agent_cmd.addr);

  // Straps wider than the store; variants use 32-word blocks
  assign cfg_err = (bstf_idx_bits(cfg_4mb, cfg_blk) > IDX_W); // R7 R9

  // Lookup and agent write strobes
  assign snp_take = snoop_req.valid && snoop_req.coherent; // R16
  assign agt_tag_wr = agent_cmd.valid &&
    (agent_cmd.op == BSTF_OP_FILL_READ ||
     agent_cmd.op == BSTF_OP_READ_WFWD); // R11 R17
  assign agt_st_wr = agent_cmd.valid && agent_cmd.op != BSTF_OP_OTHER; // R13

  // Compare and filter decision
  assign tag_match = (tag_mem[snp_idx] == snp_tag); // R2 R4
  assign cur_state = state_mem[snp_idx];
  assign hit_now = tag_match || force_hit_q; // R12
  assign nonexcl_read = !snoop_req.excl;
  assign blocked = nonexcl_read && !force_hit_q &&
    (cur_state == BSTF_ST_SHARED ||
     cur_state == BSTF_ST_INVALID); // R13
  assign bus_inval = snp_take && snoop_req.excl && tag_match &&
    !(agt_st_wr && agt_idx == snp_idx);

  // Tag store writes from the agent
  always_ff @(posedge clk_sys) begin
    if (clk_en && agt_tag_wr) begin
      tag_mem[agt_idx] <= agt_tag; // R11 R17
    end
  end

  // State tracking; agent wins over a bus invalidate on the same set
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (agt_st_wr) begin
        state_mem[agt_idx] <= agent_cmd.state; // R13
      end
      if (bus_inval) begin
        state_mem[snp_idx] <= BSTF_ST_INVALID; // R13
      end
    end
  end

  // Forced hit: set by replacement, ended by the next agent command
  always_comb begin
    force_hit_d = force_hit_q;
    if (agent_cmd.valid) begin
      force_hit_d = (agent_cmd.op == BSTF_OP_READ_WFWD); // R12
    end
  end

  // Forced-hit flag register, frozen with the clock enable
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (!rst_b) begin
        force_hit_q <= RST_FORCE_HIT;
      end else begin
        force_hit_q <= force_hit_d; // R12
      end
    end
  end

  // Registered snoop answer, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (!rst_b) begin
        rsp_valid_q <= RST_RSP_VALID;
        rsp_hit_q <= RST_RSP_HIT;
        rsp_fwd_q <= RST_RSP_FWD;
      end else begin
        rsp_valid_q <= snp_take; // R16
        if (snp_take) begin
          rsp_hit_q <= hit_now; // R2 R12
          rsp_fwd_q <= hit_now && !blocked; // R13
        end else begin
          rsp_hit_q <= 1'b0;
          rsp_fwd_q <= 1'b0;
        end
      end
    end
  end

  // Tracked state seen by the last lookup, held between answers
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (!rst_b) begin
        rsp_state_q <= RST_RSP_STATE;
      end else if (snp_take) begin
        rsp_state_q <= cur_state; // R13
      end
    end
  end

  // Snoop answer fields, all straight from flip-flops
  assign snoop_rsp.valid = rsp_valid_q;
  assign snoop_rsp.hit = rsp_hit_q;
  assign snoop_rsp.forward = rsp_fwd_q;
  assign snoop_rsp.state = rsp_state_q;

endmodule

// *** src/bstf_pkg.sv ***
package bstf_pkg;

  // Physical address and tag geometry
  localparam int ADDR_W = 36;
  localparam int TAG_HI = 35;
  localparam int TAG_LO_1MB = 20;
  localparam int TAG_LO_4MB = 22;
  localparam int TAG_W = TAG_HI - TAG_LO_1MB + 1;

  // Highest offset bit for each block size
  localparam int OFF_HI_8W = 4;
  localparam int OFF_HI_16W = 5;
  localparam int OFF_HI_32W = 6;

  // Index limit of the tag store
  localparam int MAX_IDX_W = 15;
  localparam int MAX_ENTRIES = 32768;

  // Reset values of control state
  localparam logic RST_FORCE_HIT = 1'b0;
  localparam logic RST_RSP_VALID = 1'b0;
  localparam logic RST_RSP_HIT = 1'b0;
  localparam logic RST_RSP_FWD = 1'b0;

  // Block size select, static strap
  typedef enum logic [1:0] {
    BSTF_BLK_8W = 2'h0,
    BSTF_BLK_16W = 2'h1,
    BSTF_BLK_32W = 2'h2
  } bstf_blk_t;

  // Tracked line state of the level_two_cache
  typedef enum logic [1:0] {
    BSTF_ST_INVALID = 2'h0,
    BSTF_ST_SHARED = 2'h1,
    BSTF_ST_CLEAN_EXCL = 2'h2,
    BSTF_ST_DIRTY_EXCL = 2'h3
  } bstf_state_t;

  // Reset value of the answer's state field
  localparam bstf_state_t RST_RSP_STATE = BSTF_ST_INVALID;

  // Commands from the local_side_agent or global_side_agent
  typedef enum logic [1:0] {
    BSTF_OP_OTHER = 2'h0,
    BSTF_OP_FILL_READ = 2'h1,
    BSTF_OP_READ_WFWD = 2'h2,
    BSTF_OP_STATE_UPD = 2'h3
  } bstf_op_t;

  // Snoop request taken from the bus address latch
  typedef struct packed {
    logic valid;
    logic coherent;
    logic excl;
    logic [ADDR_W-1:0] addr;
  } bstf_snoop_req_t;

  // Agent command
  typedef struct packed {
    logic valid;
    bstf_op_t op;
    bstf_state_t state;
    logic [ADDR_W-1:0] addr;
  } bstf_agent_cmd_t;

  // Snoop answer to the agent
  typedef struct packed {
    logic valid;
    logic hit;
    logic forward;
    bstf_state_t state;
  } bstf_snoop_rsp_t;

endpackage

// *** tb/bstf_agent_model.sv ***
`timescale 1ns/100ps
module bstf_agent_model
  import bstf_pkg::*;
(
  input wire logic clk_sys,
  output bstf_agent_cmd_t agent_cmd
);
  logic [ADDR_W-1:0] keep_addr;
  // Idle agent
  initial begin
    agent_cmd = '0;
    keep_addr = '0;
  end
  // One command for one cycle; address lines toggle once released
  task automatic issue(input bstf_op_t op, input bstf_state_t st,
    input logic [ADDR_W-1:0] a);
    @(negedge clk_sys);
    agent_cmd = '{1'b1, op, st, a};
    if (op == BSTF_OP_READ_WFWD)
      keep_addr = a;
    @(negedge clk_sys);
    agent_cmd = '{1'b0, BSTF_OP_OTHER, BSTF_ST_INVALID, ~a};
  endtask
endmodule

// *** tb/bstf_chk_sva.sv ***
`timescale 1ns/100ps
module bstf_chk_sva
  import bstf_pkg::*;
#(
  parameter int IDX_W = MAX_IDX_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cfg_4mb,
  input wire bstf_blk_t cfg_blk,
  input wire bstf_snoop_req_t snoop_req,
  input wire bstf_agent_cmd_t agent_cmd,
  input wire bstf_snoop_rsp_t snoop_rsp,
  input wire logic cfg_err
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic tk;
  logic wf;
  int need;
  // Taken lookup, replacement command, index bits the straps ask for
  assign tk = clk_en && snoop_req.valid && snoop_req.coherent;
  assign wf = clk_en && agent_cmd.valid && agent_cmd.op == BSTF_OP_READ_WFWD;
  assign need = (cfg_4mb ? 22 : 20) - (cfg_blk == BSTF_BLK_8W ? 5 :
    cfg_blk == BSTF_BLK_16W ? 6 : 7);
  chk_rsp_next: assert property (tk |=> snoop_rsp.valid)
    else $error("answer missing");
  chk_noncoh_drop: assert property (clk_en && !tk |=> !snoop_rsp.valid)
    else $error("answer without lookup");
  chk_idle_quiet: assert property (!snoop_rsp.valid |-> !snoop_rsp.hit)
    else $error("hit while idle");
  chk_fwd_hit: assert property (snoop_rsp.forward |-> snoop_rsp.hit)
    else $error("forward without hit");
  chk_force_hit: assert property (wf ##1 tk |=> snoop_rsp.hit
    && snoop_rsp.forward)
    else $error("forced hit missing");
  chk_excl_pass: assert property (tk && snoop_req.excl |=>
    snoop_rsp.forward == snoop_rsp.hit)
    else $error("exclusive read blocked");
  chk_block_state: assert property (snoop_rsp.hit && !snoop_rsp.forward |->
    snoop_rsp.state inside {BSTF_ST_INVALID, BSTF_ST_SHARED})
    else $error("blocked in exclusive state");
  chk_cfg_err: assert property (cfg_err == (need > IDX_W))
    else $error("strap error flag wrong");
  cov_hit: cover property (tk ##1 snoop_rsp.hit);
  cov_block: cover property (snoop_rsp.hit && !snoop_rsp.forward);
  cov_force: cover property (wf ##1 tk);
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
  import bstf_pkg::*;
  localparam logic [ADDR_W-1:0] A = 36'hA5C31F0E5;
  localparam logic [ADDR_W-1:0] T = 36'h800000000;
  logic clk_sys;
  logic rst_b;
  logic clk_en;
  logic cfg_4mb;
  logic cfg_err;
  bstf_blk_t cfg_blk;
  bstf_snoop_req_t snoop_req;
  bstf_agent_cmd_t agent_cmd;
  bstf_snoop_rsp_t snoop_rsp;
  int fails;
  int total_checks;
  bstf_bus_snoop_tag_filter u_bstf_bus_snoop_tag_filter (.clk_sys(clk_sys),
    .rst_b(rst_b), .clk_en(clk_en), .cfg_4mb(cfg_4mb), .cfg_blk(cfg_blk),
    .snoop_req(snoop_req), .agent_cmd(agent_cmd), .snoop_rsp(snoop_rsp),
    .cfg_err(cfg_err));
  bstf_agent_model u_bstf_agent_model (.clk_sys(clk_sys),
    .agent_cmd(agent_cmd));
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_st(input bstf_state_t got, input bstf_state_t exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t state %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmd(input bstf_op_t op, input bstf_state_t st,
    input logic [ADDR_W-1:0] a);
    u_bstf_agent_model.issue(op, st, a);
  endtask
  // Lookup, answer due one cycle after it is taken
  task automatic look(input logic [ADDR_W-1:0] a, input logic ex, eh, ef);
    @(negedge clk_sys);
    snoop_req = '{1'b1, 1'b1, ex, a};
    @(negedge clk_sys);
    snoop_req = '{1'b0, 1'b0, 1'b0, ~a};
    chk(snoop_rsp.valid, 1'b1);
    chk(snoop_rsp.hit, eh);
    chk(snoop_rsp.forward, ef);
  endtask
  // Tag match, offset ignored, non-coherent refused
  task automatic s_match();
    cmd(BSTF_OP_FILL_READ, BSTF_ST_CLEAN_EXCL, A);
    look(A ^ 36'h1F, 1'b0, 1'b1, 1'b1);
    look(A ^ T, 1'b0, 1'b0, 1'b0);
    @(negedge clk_sys);
    snoop_req = '{1'b1, 1'b0, 1'b0, A};
    @(negedge clk_sys);
    snoop_req = '{1'b0, 1'b0, 1'b0, ~A};
    chk(snoop_rsp.valid, 1'b0);
  endtask
  // Every tracked state, then a state-only update
  task automatic s_state();
    for (int k = 0; k < 4; k++) begin
      cmd(BSTF_OP_FILL_READ, bstf_state_t'(k), A);
      look(A, 1'b0, 1'b1, k >= 2);
      chk_st(snoop_rsp.state, bstf_state_t'(k));
    end
    look(A, 1'b1, 1'b1, 1'b1);
    look(A, 1'b0, 1'b1, 1'b0);
    chk_st(snoop_rsp.state, BSTF_ST_INVALID);
    cmd(BSTF_OP_STATE_UPD, BSTF_ST_SHARED, A ^ T);
    look(A, 1'b0, 1'b1, 1'b0);
    chk_st(snoop_rsp.state, BSTF_ST_SHARED);
  endtask
  // Replacement overwrites the tag and forces hits until the next command
  task automatic s_wfwd();
    cmd(BSTF_OP_FILL_READ, BSTF_ST_SHARED, A);
    cmd(BSTF_OP_READ_WFWD, BSTF_ST_SHARED, A ^ T);
    look(A, 1'b0, 1'b1, 1'b1);
    look(A ^ 36'h40000, 1'b0, 1'b1, 1'b1);
    cmd(BSTF_OP_OTHER, BSTF_ST_SHARED, A);
    look(A, 1'b0, 1'b0, 1'b0);
    look(A ^ T, 1'b1, 1'b1, 1'b1);
  endtask
  // Lookup right behind a replacement, then reset ends the forced hit
  task automatic s_reset();
    cmd(BSTF_OP_READ_WFWD, BSTF_ST_SHARED, A ^ T);
    snoop_req = '{1'b1, 1'b1, 1'b0, A};
    @(negedge clk_sys);
    snoop_req = '{1'b0, 1'b0, 1'b0, ~A};
    chk(snoop_rsp.valid, 1'b1);
    chk(snoop_rsp.hit, 1'b1);
    chk(snoop_rsp.forward, 1'b1);
    @(negedge clk_sys);
    rst_b = 1'b0;
    @(negedge clk_sys);
    rst_b = 1'b1;
    look(A, 1'b0, 1'b0, 1'b0);
  endtask
  // Clock enable low: agent write and lookup are both ignored
  task automatic s_freeze();
    @(negedge clk_sys);
    clk_en = 1'b0;
    snoop_req = '{1'b1, 1'b1, 1'b0, A};
    cmd(BSTF_OP_FILL_READ, BSTF_ST_CLEAN_EXCL, A);
    chk(snoop_rsp.valid, 1'b0);
    snoop_req = '{1'b0, 1'b0, 1'b0, ~A};
    clk_en = 1'b1;
    look(A, 1'b0, 1'b0, 1'b0);
  endtask
  // A flipped bit either shares the entry of A or lands elsewhere
  task automatic geo(input bstf_blk_t blk, input logic m4, input int n,
    input logic eh);
    cfg_blk = blk;
    cfg_4mb = m4;
    cmd(BSTF_OP_FILL_READ, BSTF_ST_CLEAN_EXCL, A);
    chk(cfg_err, 1'b0);
    cmd(BSTF_OP_FILL_READ, BSTF_ST_CLEAN_EXCL, A ^ T ^ (36'h1 << n));
    look(A, 1'b0, eh, eh);
  endtask
  // Strap needing more index bits than the store holds
  task automatic s_strap();
    cfg_blk = BSTF_BLK_8W;
    cfg_4mb = 1'b1;
    @(negedge clk_sys);
    chk(cfg_err, 1'b1);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    cfg_4mb = 1'b0;
    cfg_blk = BSTF_BLK_32W;
    snoop_req = '0;
    fails = 0;
    total_checks = 0;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    s_match();
    s_state();
    s_wfwd();
    s_reset();
    s_freeze();
    geo(BSTF_BLK_32W, 1'b0, 20, 1'b0);
    geo(BSTF_BLK_32W, 1'b1, 20, 1'b1);
    geo(BSTF_BLK_32W, 1'b0, 6, 1'b0);
    geo(BSTF_BLK_8W, 1'b0, 6, 1'b1);
    geo(BSTF_BLK_16W, 1'b0, 5, 1'b0);
    geo(BSTF_BLK_8W, 1'b0, 5, 1'b1);
    s_strap();
    conclude();
  end
endmodule
bind bstf_bus_snoop_tag_filter bstf_chk_sva #(.IDX_W(IDX_W)) u_bstf_chk_sva (
  .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .cfg_4mb(cfg_4mb),
  .cfg_blk(cfg_blk), .snoop_req(snoop_req), .agent_cmd(agent_cmd),
  .snoop_rsp(snoop_rsp), .cfg_err(cfg_err));
